// [verilog/pms_pkg.sv]
// Constants, register map and state types of the power mode sequencer.
// Assumes an APB master with 32-bit data and a 10 MHz core clock.
//
// What this block does
// - Sleep stops system clock and oscillator, halts CPU, freezes pins.
// - Idle stops the CPU while system and peripheral clocks keep running.
// - Deep Sleep stops clocks and peripherals, freezes pins, cuts memory power.
// - Enabled interrupt, watchdog time-out or reset wakes Sleep or Idle.
// - Watchdog count is cleared on entry into Sleep or Idle when enabled.
// - Low-power RC keeps running in Sleep if watchdog or calendar needs it.
// - Wake from Sleep resumes on the clock source active at entry.
// - Wake from Idle restores the CPU clock and resumes at once.
// - Interrupt during Sleep or Idle entry is deferred, then wakes at once.
// - Arm bit not followed promptly by power-save is cleared by hardware.
// - Arm bit, bit 15 of deep control, clears on Deep Sleep exit.
// - Setting the arm bit clears all wake-source flags.
// - Deep Sleep exits on POR, watchdog, calendar alarm, master clear, ext 0.
// - External interrupt 0 wakes only if enabled before, on change to polarity.
// - Interrupts pending at Deep Sleep entry are cleared.
// - Deep exit acts as POR but scratch registers and flags survive.
// - Wake events during the post-exit reset sequence are ignored.
// - Deep exit sets bit 10 of reset cause; software clears it.
// - Brown-out in Deep Sleep is reported in bit 1 of deep control.
// - Pins stay held while the hold bit is set after wake-up.
// - Brown-out in Deep Sleep does not wake the device.
// - Power-save zero enters Deep Sleep if armed, else normal Sleep.
package pms_pkg;

    localparam logic [7:0]  OFS_DSCTL  = 8'h00;
    localparam logic [7:0]  OFS_WAKE   = 8'h04;
    localparam logic [7:0]  OFS_RCAUSE = 8'h08;
    localparam logic [7:0]  OFS_SCR0   = 8'h0C;
    localparam logic [7:0]  OFS_SCR1   = 8'h10;
    localparam logic [7:0]  OFS_CFG    = 8'h14;
    localparam logic [7:0]  OFS_STAT   = 8'h18;

    localparam int          B_ARM      = 15;
    localparam int          B_BROWN    = 1;
    localparam int          B_REL      = 0;
    localparam int          B_XFLAG    = 10;
    localparam int          B_W_EXT0   = 8;
    localparam int          B_W_WDT    = 4;
    localparam int          B_W_CAL    = 3;
    localparam int          B_W_MASTER_CLEAR_PIN   = 2;
    localparam logic [8:0]  WAKE_MASK  = 9'h11C;

    localparam int          C_WDT      = 0;
    localparam int          C_CAL      = 1;
    localparam int          C_CALLPRC  = 2;
    localparam int          C_EXT0     = 3;
    localparam int          C_POL      = 4;
    localparam int          C_CLOCK_FAIL_MONITOR     = 5;
    localparam int          C_BOR      = 6;

    localparam logic [1:0]  ARM_NOPS   = 2'h3;
    localparam int          CLK_NS     = 100;
    localparam int          POR_SEQ_NS = 1000;
    localparam int          POR_CYC    = (POR_SEQ_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ST_RUN, ST_ENTER, ST_SLEEP, ST_IDLE, ST_DEEP, ST_DEXIT
    } pms_st_e;

    typedef enum logic [1:0] {
        MD_SLEEP, MD_IDLE, MD_DEEP
    } pms_md_e;

endpackage

// [verilog/pms_top.sv]
// Power mode sequencer: power-save entry, wake-up and deep sleep control.
// Assumes a CPU core issuing power-save pulses and synchronous wake inputs.
//
// Decided for this implementation: the APB register port and the placing of the registers.
module pms_top
    import pms_pkg::*;
(
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_POWER_SAVE_INSTR_VALID,
    input  wire logic        I_POWER_SAVE_INSTR_OP,
    input  wire logic        I_INSTR_RETIRE,
    input  wire logic [2:0]  I_CLK_SRC,
    input  wire logic        I_IRQ_PEND,
    input  wire logic        I_WDT_TIMEOUT,
    input  wire logic        I_DEEP_SLEEP_WATCHDOG_TIMEOUT,
    input  wire logic        I_CAL_ALARM,
    input  wire logic        I_MASTER_CLEAR_PIN_N,
    input  wire logic        I_EXT0,
    input  wire logic        I_BOR,
    output logic             O_CPU_CLK_EN,
    output logic             O_PERIPH_CLK_EN,
    output logic             O_SYS_OSC_EN,
    output logic             O_LOW_POWER_RC_OSC_EN,
    output logic             O_WDT_CLR,
    output logic             O_IRQ_CLR,
    output logic             O_IO_FREEZE,
    output logic             O_IO_HOLD,
    output logic             O_MEM_PWR_EN,
    output logic             O_WAKE,
    output logic             O_CORE_RST,
    output logic [2:0]       O_RESUME_SRC
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        pms_st_e     st;
        pms_md_e     md;
        logic        arm;
        logic [1:0]  arm_cnt;
        logic        brown;
        logic        rel;
        logic [8:0]  wake;
        logic        xflag;
        logic [15:0] scr0;
        logic [15:0] scr1;
        logic [6:0]  cfg;
        logic        ext_en;
        logic        ext_p;
        logic [7:0]  por_cnt;
        logic [2:0]  src;
        logic        sreq;
        logic        ireq;
        logic [31:0] rdata;
        logic        rdy;
        logic        err;
        logic        cpu;
        logic        per;
        logic        osc;
        logic        low_power_rc_osc;
        logic        wclr;
        logic        iclr;
        logic        frz;
        logic        mem;
        logic        wk;
        logic        crst;
    } pms_state_s;

    pms_state_s s_q;
    pms_state_s s_d;

    logic       acc;
    logic       wr;
    logic       ext_hit;
    logic [8:0] dwake;
    logic       low_power_rc_osc_need;

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_d       = s_q;
        s_d.sreq  = 1'b0;
        s_d.ireq  = 1'b0;
        s_d.wclr  = 1'b0;
        s_d.iclr  = 1'b0;
        s_d.wk    = 1'b0;
        s_d.err   = 1'b0;
        acc       = I_PSEL & I_PENABLE;
        wr        = acc & I_PWRITE & s_q.rdy & ~s_q.err;
        ext_hit   = s_q.ext_en & (I_EXT0 == s_q.cfg[C_POL])
                  & (s_q.ext_p != s_q.cfg[C_POL]);
        dwake     = '0;
        dwake[B_W_EXT0] = ext_hit;
        dwake[B_W_WDT]  = I_DEEP_SLEEP_WATCHDOG_TIMEOUT;
        dwake[B_W_CAL]  = I_CAL_ALARM & s_q.cfg[C_CAL];
        dwake[B_W_MASTER_CLEAR_PIN] = ~I_MASTER_CLEAR_PIN_N;
        low_power_rc_osc_need = s_q.cfg[C_WDT]
                  | (s_q.cfg[C_CAL] & s_q.cfg[C_CALLPRC]);
        s_d.ext_p = I_EXT0;

        // Bus slave, one wait state
        s_d.rdy = acc & ~s_q.rdy;
        if (acc && !s_q.rdy)
        begin
            s_d.err   = 1'b0;
            s_d.rdata = '0;
            case (I_PADDR)
                OFS_DSCTL:
                begin
                    s_d.rdata[B_ARM]   = s_q.arm;
                    s_d.rdata[B_BROWN] = s_q.brown;
                    s_d.rdata[B_REL]   = s_q.rel;
                end
                OFS_WAKE:   s_d.rdata[8:0]      = s_q.wake;
                OFS_RCAUSE: s_d.rdata[B_XFLAG]  = s_q.xflag;
                OFS_SCR0:   s_d.rdata[15:0]     = s_q.scr0;
                OFS_SCR1:   s_d.rdata[15:0]     = s_q.scr1;
                OFS_CFG:    s_d.rdata[6:0]      = s_q.cfg;
                OFS_STAT:
                begin
                    s_d.rdata[2:0] = s_q.st;
                    s_d.rdata[5:4] = s_q.md;
                    s_d.rdata[10:8] = s_q.src;
                end
                default:    s_d.err = 1'b1;
            endcase
        end

        if (wr)
        begin
            case (I_PADDR)
                OFS_DSCTL:
                begin
                    s_d.arm   = I_PWDATA[B_ARM];
                    s_d.brown = I_PWDATA[B_BROWN];
                    if (!I_PWDATA[B_REL])
                        s_d.rel = 1'b0;
                end
                OFS_WAKE:   s_d.wake  = I_PWDATA[8:0] & WAKE_MASK;
                OFS_RCAUSE: s_d.xflag = I_PWDATA[B_XFLAG];
                OFS_SCR0:   s_d.scr0  = I_PWDATA[15:0];
                OFS_SCR1:   s_d.scr1  = I_PWDATA[15:0];
                OFS_CFG:    s_d.cfg   = I_PWDATA[6:0];
                default:    s_d.cfg   = s_q.cfg;
            endcase
        end

        // Arming window
        if (s_d.arm && !s_q.arm)
        begin
            s_d.wake    = '0;
            s_d.arm_cnt = '0;
        end
        else if (s_q.arm && s_q.st == ST_RUN && I_INSTR_RETIRE
                 && !I_POWER_SAVE_INSTR_VALID)
        begin
            if (s_q.arm_cnt == ARM_NOPS)
                s_d.arm = 1'b0;
            else
                s_d.arm_cnt = s_q.arm_cnt + 2'h1;
        end

        // Sequencer
        case (s_q.st)
            ST_RUN:
            begin
                if (s_q.sreq || s_q.ireq)
                begin
                    s_d.st   = ST_ENTER;
                    s_d.md   = s_q.ireq ? MD_IDLE
                             : (s_q.arm ? MD_DEEP : MD_SLEEP);
                    s_d.wclr = s_q.cfg[C_WDT];
                    s_d.iclr = s_q.sreq & s_q.arm;
                end
                else if (I_POWER_SAVE_INSTR_VALID)
                begin
                    s_d.sreq = ~I_POWER_SAVE_INSTR_OP;
                    s_d.ireq = I_POWER_SAVE_INSTR_OP;
                end
            end
            ST_ENTER:
            begin
                // Wake sources are not looked at here
                s_d.src    = I_CLK_SRC;
                s_d.ext_en = s_q.cfg[C_EXT0];
                case (s_q.md)
                    MD_IDLE:  s_d.st = ST_IDLE;
                    MD_DEEP:
                    begin
                        s_d.st  = ST_DEEP;
                        s_d.rel = 1'b1;
                    end
                    default:  s_d.st = ST_SLEEP;
                endcase
            end
            ST_SLEEP, ST_IDLE:
            begin
                if (I_IRQ_PEND || I_WDT_TIMEOUT || !I_MASTER_CLEAR_PIN_N)
                begin
                    s_d.st = ST_RUN;
                    s_d.wk = 1'b1;
                end
            end
            ST_DEEP:
            begin
                if (I_BOR && s_q.cfg[C_BOR])
                    s_d.brown = 1'b1;
                if (|dwake)
                begin
                    s_d.wake    = s_q.wake | dwake;
                    s_d.st      = ST_DEXIT;
                    s_d.arm     = 1'b0;
                    s_d.xflag   = 1'b1;
                    s_d.por_cnt = '0;
                end
            end
            ST_DEXIT:
            begin
                // Wake events ignored until reset sequence ends
                s_d.por_cnt = s_q.por_cnt + 8'h01;
                if (s_q.por_cnt == 8'(POR_CYC - 1))
                    s_d.st = ST_RUN;
            end
            default: s_d.st = ST_RUN;
        endcase

        // Clock, power and pin controls
        s_d.cpu  = (s_d.st == ST_RUN);
        s_d.per  = (s_d.st == ST_RUN) || (s_d.st == ST_ENTER)
                || (s_d.st == ST_IDLE) || (s_d.st == ST_DEXIT);
        s_d.osc  = (s_d.st != ST_SLEEP) && (s_d.st != ST_DEEP);
        s_d.frz  = (s_d.st == ST_SLEEP) || (s_d.st == ST_DEEP);
        s_d.mem  = (s_d.st != ST_DEEP);
        s_d.crst = (s_d.st == ST_DEXIT);
        case (s_d.st)
            ST_SLEEP, ST_DEEP: s_d.low_power_rc_osc = low_power_rc_osc_need;
            ST_IDLE:  s_d.low_power_rc_osc = low_power_rc_osc_need | s_q.cfg[C_CLOCK_FAIL_MONITOR];
            default:  s_d.low_power_rc_osc = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers, all in the always-powered domain

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            s_q      <= '0;
            s_q.st   <= ST_RUN;
            s_q.md   <= MD_SLEEP;
            s_q.cpu  <= 1'b1;
            s_q.per  <= 1'b1;
            s_q.osc  <= 1'b1;
            s_q.low_power_rc_osc <= 1'b1;
            s_q.mem  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign O_PRDATA        = s_q.rdata;
    assign O_PREADY        = s_q.rdy;
    assign O_PSLVERR       = s_q.err;
    assign O_CPU_CLK_EN    = s_q.cpu;
    assign O_PERIPH_CLK_EN = s_q.per;
    assign O_SYS_OSC_EN    = s_q.osc;
    assign O_LOW_POWER_RC_OSC_EN       = s_q.low_power_rc_osc;
    assign O_WDT_CLR       = s_q.wclr;
    assign O_IRQ_CLR       = s_q.iclr;
    assign O_IO_FREEZE     = s_q.frz;
    assign O_IO_HOLD       = s_q.rel;
    assign O_MEM_PWR_EN    = s_q.mem;
    assign O_WAKE          = s_q.wk;
    assign O_CORE_RST      = s_q.crst;
    assign O_RESUME_SRC    = s_q.src;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    AST_SLEEP_CLK: assert property (s_q.st == ST_SLEEP |->
        !O_SYS_OSC_EN && !O_CPU_CLK_EN && O_IO_FREEZE)
        else $error("Sleep clocks not stopped");
    AST_IDLE_CLK: assert property (s_q.st == ST_IDLE |->
        O_PERIPH_CLK_EN && O_SYS_OSC_EN && !O_CPU_CLK_EN)
        else $error("Idle clocks wrong");
    AST_DEEP_PWR: assert property (s_q.st == ST_DEEP |->
        !O_MEM_PWR_EN && !O_PERIPH_CLK_EN && O_IO_FREEZE)
        else $error("Deep sleep power wrong");
    AST_WAKE: assert property ((s_q.st == ST_SLEEP
        || s_q.st == ST_IDLE) && I_IRQ_PEND |=> O_WAKE && O_CPU_CLK_EN)
        else $error("No wake on interrupt");
    AST_WDT_CLR: assert property (s_q.st == ST_ENTER
        && $past(s_q.cfg[C_WDT]) && s_q.md != MD_DEEP |-> O_WDT_CLR)
        else $error("Watchdog not cleared");
    AST_LOW_POWER_RC_OSC: assert property (s_q.st == ST_SLEEP
        && s_q.cfg[C_WDT] |-> O_LOW_POWER_RC_OSC_EN)
        else $error("Low-power RC stopped");
    AST_RESUME: assert property (s_q.st == ST_ENTER
        |=> O_RESUME_SRC == $past(I_CLK_SRC))
        else $error("Resume source not saved");
    AST_DEFER: assert property (s_q.st == ST_ENTER && I_IRQ_PEND
        |=> !O_CPU_CLK_EN)
        else $error("Entry not completed");
    AST_ARM_FLAGS: assert property ($rose(s_q.arm) |-> s_q.wake == 9'h000)
        else $error("Wake flags not cleared");
    AST_DEXIT: assert property ($rose(s_q.st == ST_DEXIT) |->
        !s_q.arm && s_q.xflag && O_CORE_RST)
        else $error("Deep exit state wrong");
    AST_BOR: assert property (s_q.st == ST_DEEP && I_BOR
        && s_q.cfg[C_BOR] && dwake == 9'h000 |=> s_q.st == ST_DEEP && s_q.brown)
        else $error("Brown-out mishandled");
    AST_IRQCLR: assert property (s_q.st == ST_ENTER
        && s_q.md == MD_DEEP |-> O_IRQ_CLR)
        else $error("Pending interrupts not cleared");

    AST_IDLE_WAKE: assert property (s_q.st == ST_IDLE
        && I_IRQ_PEND |=> s_q.st == ST_RUN && O_CPU_CLK_EN && O_WAKE)
        else $error("Idle wake late");

    AST_ARM_DROP: assert property (s_q.arm && s_q.st == ST_RUN
        && I_INSTR_RETIRE && !I_POWER_SAVE_INSTR_VALID && !wr
        && s_q.arm_cnt == ARM_NOPS |=> !s_q.arm)
        else $error("Arm bit not dropped");

    AST_EXT0_LEVEL: assert property (s_q.st == ST_DEEP && s_q.ext_en
        && I_EXT0 != s_q.cfg[C_POL] && !I_DEEP_SLEEP_WATCHDOG_TIMEOUT && !I_CAL_ALARM
        && I_MASTER_CLEAR_PIN_N |=> s_q.st == ST_DEEP)
        else $error("Ext 0 woke on wrong level");

    AST_POR_QUIET: assert property (s_q.st == ST_DEXIT && !wr
        |=> $stable(s_q.wake))
        else $error("Wake flag taken during reset");

    AST_POR_LEN: assert property (s_q.st == ST_DEXIT
        && s_q.por_cnt == 8'(POR_CYC - 1) |=> s_q.st == ST_RUN && !O_CORE_RST)
        else $error("Reset sequence length wrong");

    AST_XFLAG: assert property (s_q.st == ST_DEEP && dwake != 9'h000
        |=> s_q.xflag && s_q.st == ST_DEXIT)
        else $error("Deep exit flag not set");

    AST_HOLD: assert property (O_IO_HOLD && !wr |=> O_IO_HOLD)
        else $error("Pin hold dropped");

    AST_MODE: assert property (s_q.st == ST_RUN && s_q.sreq
        |=> s_q.md == ($past(s_q.arm) ? MD_DEEP : MD_SLEEP))
        else $error("Sleep mode choice wrong");

    AST_REQ_PULSE: assert property (s_q.sreq || s_q.ireq
        |=> !s_q.sreq && !s_q.ireq)
        else $error("Power-save request not a pulse");

endmodule

// [verif/pms_cpu_model.sv]
// CPU core model: retires plain instructions and issues power-save pulses.
// Assumes the bench calls its tasks right after a rising clock edge.
module pms_cpu_model
(
    input  wire logic clk,
    output logic      o_valid,
    output logic      o_op,
    output logic      o_retire
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        o_valid  = 1'b0;
        o_op     = 1'b1;
        o_retire = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One retire pulse per plain instruction
    task automatic nops(input int n);
        repeat (n)
        begin
            @(posedge clk);
            o_retire <= 1'b1;
        end
        @(posedge clk);
        o_retire <= 1'b0;
    endtask

    // Operand is inverted once released, so it is never stale
    task automatic power_save_instr(input logic op);
        @(posedge clk);
        o_valid <= 1'b1;
        o_op    <= op;
        @(posedge clk);
        o_valid <= 1'b0;
        o_op    <= ~op;
    endtask
endmodule

// [verif/power_mode_sequencer_bench.sv]
// Self-checking bench of the power mode sequencer with a CPU core model.
// Assumes the APB slave answers with pready and outputs are registered.
module power_mode_sequencer_bench import pms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst, psel, penable, pwrite, irq, wdt_to, deep_sleep_watchdog, cal, master_clear_pin_n, ext0;
    logic        bor, pready, pslverr, pv, pop, pret, err;
    logic        cpu_en, per_en, osc_en, low_power_rc_osc_en, wdt_clr, irq_clr, frz, hold, mem_en;
    logic        wake, core_rst;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, tmp;
    logic [2:0]  csrc, rsrc, esrc;
    int          fail_count, num_checks, wdt_n, iclr_n, wake_n, seed, k, n, n0, j;

    pms_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_POWER_SAVE_INSTR_VALID(pv), .I_POWER_SAVE_INSTR_OP(pop),
        .I_INSTR_RETIRE(pret), .I_CLK_SRC(csrc), .I_IRQ_PEND(irq), .I_WDT_TIMEOUT(wdt_to),
        .I_DEEP_SLEEP_WATCHDOG_TIMEOUT(deep_sleep_watchdog), .I_CAL_ALARM(cal), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n), .I_EXT0(ext0),
        .I_BOR(bor), .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_SYS_OSC_EN(osc_en),
        .O_LOW_POWER_RC_OSC_EN(low_power_rc_osc_en), .O_WDT_CLR(wdt_clr), .O_IRQ_CLR(irq_clr), .O_IO_FREEZE(frz),
        .O_IO_HOLD(hold), .O_MEM_PWR_EN(mem_en), .O_WAKE(wake), .O_CORE_RST(core_rst),
        .O_RESUME_SRC(rsrc));

    pms_cpu_model cpu (.clk(clk), .o_valid(pv), .o_op(pop), .o_retire(pret));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Pulse counters, read only cycles after the pulse
    always @(posedge clk)
    begin
        if (wdt_clr === 1'b1) wdt_n++;
        if (irq_clr === 1'b1) iclr_n++;
        if (wake === 1'b1) wake_n++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic give_up;
        fail_count++;
        $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int c;
        c = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            c++;
        end
        while (pready !== 1'b1 && c < 16);
        if (pready !== 1'b1) give_up();
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    function automatic logic sig(input int s);
        case (s)
            0:       return cpu_en;
            1:       return core_rst;
            2:       return mem_en;
            default: return frz;
        endcase
    endfunction

    task automatic wait_on(input int s, input logic v);
        int c;
        c = 0;
        while (sig(s) !== v && c < 200)
        begin
            @(posedge clk);
            c++;
        end
        if (sig(s) !== v) give_up();
    endtask

    // Deep wake sources: deep watchdog, calendar, master clear, ext 0
    task automatic src(input int s, input logic v);
        case (s)
            0:       deep_sleep_watchdog  <= v;
            1:       cal    <= v;
            2:       master_clear_pin_n <= ~v;
            default: ext0   <= v;
        endcase
    endtask

    function automatic logic [31:0] wbit(input int s);
        case (s)
            0:       return 32'h1 << B_W_WDT;
            1:       return 32'h1 << B_W_CAL;
            2:       return 32'h1 << B_W_MASTER_CLEAR_PIN;
            default: return 32'h1 << B_W_EXT0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, irq, wdt_to, deep_sleep_watchdog, cal, ext0, bor} = '0;
        {paddr, pwdata, csrc} = '0;
        {fail_count, num_checks, wdt_n, iclr_n, wake_n} = '0;
        master_clear_pin_n = 1'b1;
        rst = 1'b1;
        seed = 32'hA4DD;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'({cpu_en, per_en, osc_en, low_power_rc_osc_en, mem_en}), 32'h1F);
        chk(32'({wdt_clr, irq_clr, frz, hold, wake, core_rst}), 32'h0);
        rchk(OFS_DSCTL, 32'h0);
        rchk(OFS_RCAUSE, 32'h0);
        rchk(OFS_STAT, 32'h0);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk(32'({err, |rd}), 32'h2);
        tmp = $random(seed);
        apb(1'b1, OFS_SCR0, {16'h0, tmp[15:0]});
        apb(1'b1, OFS_SCR1, {16'h0, ~tmp[15:0]});
        apb(1'b1, OFS_CFG, 32'h1);
        // Sleep and idle, woken by interrupt, watchdog, master clear
        for (k = 0; k < 7; k++)
        begin
            esrc = 3'($random(seed));
            csrc <= esrc;
            n0 = wdt_n;
            j = wake_n;
            if (k == 6) irq <= 1'b1;
            cpu.power_save_instr(k[0]);
            wait_on(3 - k[0] * 3, ~k[0]);
            wait_on(0, 1'b0);
            csrc <= ~esrc;
            repeat (2) @(posedge clk);
            chk(32'(wdt_n - n0), 32'h1);
            if (k[0] == 1'b0 && k < 6)
                chk(32'({per_en, osc_en, frz, low_power_rc_osc_en, mem_en}), 32'h7);
            else if (k < 6)
                chk(32'({per_en, osc_en, frz, low_power_rc_osc_en}), 32'hD);
            chk(32'(rsrc), 32'(esrc));
            case (k / 2)
                0:       irq    <= 1'b1;
                1:       wdt_to <= 1'b1;
                default: master_clear_pin_n <= 1'b0;
            endcase
            wait_on(0, 1'b1);
            @(posedge clk);
            {irq, wdt_to, master_clear_pin_n} <= 3'b001;
            chk(32'({wake_n - j, frz}), 32'h2);
        end
        // Arm not followed promptly by power-save, then plain sleep
        apb(1'b1, OFS_DSCTL, 32'h8000);
        cpu.nops(4);
        rchk(OFS_DSCTL, 32'h0);
        cpu.power_save_instr(1'b0);
        wait_on(0, 1'b0);
        repeat (2) @(posedge clk);
        chk(32'(mem_en), 32'h1);
        irq <= 1'b1;
        wait_on(0, 1'b1);
        @(posedge clk);
        irq <= 1'b0;
        apb(1'b1, OFS_CFG, 32'h5A);
        for (k = 0; k < 4; k++)
        begin
            apb(1'b1, OFS_WAKE, 32'(WAKE_MASK));
            apb(1'b1, OFS_DSCTL, 32'h8000);
            rchk(OFS_WAKE, 32'h0);
            n0 = iclr_n;
            cpu.nops(3);
            cpu.power_save_instr(1'b0);
            wait_on(2, 1'b0);
            @(posedge clk);
            chk(32'(iclr_n - n0), 32'h1);
            chk(32'({cpu_en, per_en, osc_en, frz, low_power_rc_osc_en}), 32'h2);
            if (k == 0) bor <= 1'b1;
            repeat (3) @(posedge clk);
            bor <= 1'b0;
            chk(32'({mem_en, core_rst}), 32'h0);
            src(k, 1'b1);
            wait_on(1, 1'b1);
            src(k, 1'b0);
            j = (k == 0) ? 1 : 0;
            n = 0;
            while (core_rst === 1'b1 && n < 50)
            begin
                @(posedge clk);
                n++;
                if (n == 2) src(j, 1'b1);
                if (n == 4) src(j, 1'b0);
            end
            chk(32'(n), 32'(POR_CYC));
            chk(32'(hold), 32'h1);
            rchk(OFS_WAKE, wbit(k));
            rchk(OFS_DSCTL, (k == 0) ? 32'h3 : 32'h1);
            rchk(OFS_RCAUSE, 32'h1 << B_XFLAG);
            rchk(OFS_SCR0, {16'h0, tmp[15:0]});
            rchk(OFS_SCR1, {16'h0, ~tmp[15:0]});
            apb(1'b1, OFS_DSCTL, 32'h0);
            apb(1'b1, OFS_RCAUSE, 32'h0);
            repeat (3) @(posedge clk);
            chk(32'(hold), 32'h0);
        end
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        give_up();
    end
endmodule
